/* File: pkg/epcl_pkg.sv */
// constants shared by the port configuration loader and its memory
package epcl_pkg;

    // =========================================================
    // configuration word addresses in the external memory
    // =========================================================
    localparam logic [7:0] WADDR_P5 = 8'h6a;      // port 5 slot word
    localparam logic [7:0] WADDR_PB_BASE = 8'h70; // port 0 budget word
    localparam logic [7:0] WADDR_PB_STEP = 8'h02; // one word per port
    localparam int NUM_PORTS = 6;                 // ports 0 to 5

    // =========================================================
    // bit positions inside the port 5 slot word
    // =========================================================
    localparam int W_SLOT = 0;      // slot implemented
    localparam int W_CLK = 1;       // slot clock from connector
    localparam int W_DSI = 2;       // device specific init
    localparam int W_LPVC = 3;      // vc1 in low priority group
    localparam int W_PNUM_LO = 4;   // logical port number, 3 bits
    localparam int W_TC_LO = 9;     // tc to vc0 map, 7 bits

    // =========================================================
    // bit positions inside a power budget word
    // =========================================================
    localparam int W_BASE_LO = 0;   // base power, 8 bits
    localparam int W_SCALE_LO = 8;  // data scale, 2 bits
    localparam int W_PMST_LO = 10;  // power state, 2 bits
    localparam int W_ALLOC = 15;    // system allocated

    // =========================================================
    // field widths
    // =========================================================
    localparam int PNUM_W = 3;
    localparam int TC_W = 7;
    localparam int BASE_W = 8;
    localparam int SCALE_W = 2;
    localparam int PMST_W = 2;
    localparam int PB_W = BASE_W + SCALE_W + PMST_W + 1;

    // stored budget entry layout: {alloc, pmst, scale, base}
    localparam int E_BASE_LO = 0;
    localparam int E_SCALE_LO = 8;
    localparam int E_PMST_LO = 10;
    localparam int E_ALLOC = 12;

    // =========================================================
    // configuration register offsets and destination bits
    // =========================================================
    localparam logic [11:0] OFF_CAP = 12'h0c0;
    localparam logic [11:0] OFF_SLOTCLK = 12'h0d0;
    localparam logic [11:0] OFF_DSI = 12'h040;
    localparam logic [11:0] OFF_LPVC = 12'h144;
    localparam logic [11:0] OFF_PNUM = 12'h0cc;
    localparam logic [11:0] OFF_TCMAP = 12'h154;
    localparam logic [11:0] OFF_PBDATA = 12'h214;
    localparam logic [11:0] OFF_PBCAP = 12'h218;
    localparam int R_SLOT = 24;
    localparam int R_CLK = 28;
    localparam int R_DSI = 21;
    localparam int R_LPVC = 4;
    localparam int R_PNUM_LO = 24;
    localparam int R_TC_LO = 1;
    localparam int R_BASE_LO = 0;
    localparam int R_SCALE_LO = 8;
    localparam int R_PMST_LO = 13;
    localparam int R_ALLOC = 0;

    // =========================================================
    // apb address layout and loader control space
    // =========================================================
    localparam int A_OFF_W = 12;             // paddr[11:0] offset
    localparam int A_PORT_LO = 12;           // paddr[14:12] port
    localparam int A_PORT_W = 3;
    localparam logic [2:0] PORT_GLOBAL = 3'h7;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam int CTRL_LOCK = 0;
    localparam int STAT_DONE = 0;
    localparam int STAT_CNT_LO = 8;
    localparam int CNT_W = 8;

endpackage

/* File: src/epcl_pbmem.sv */
// small budget word store with a registered read port
`timescale 1ns/1ns
module epcl_pbmem #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 6,
    parameter int AW = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // one entry per port
        logic [WIDTH-1:0] rdata;          // registered read data
    } epcl_mem_t;

    epcl_mem_t mem_q;
    epcl_mem_t mem_d;

    // next state: write, then look up the read address
    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d.mem[wr_addr] = wr_data;
        end
        // read shows the old word on a same-cycle write
        mem_d.rdata = mem_q.mem[rd_addr];
    end

    // entries are not cleared; the owner tracks which are valid
    always_ff @(posedge clk_sys) begin
        mem_q.mem <= mem_d.mem;
        if (rst) begin
            mem_q.rdata <= '0;
        end else begin
            mem_q.rdata <= mem_d.rdata;
        end
    end

    assign rd_data = mem_q.rdata;

endmodule

/* File: src/epcl_loader.sv */
// port configuration loader: scatters memory words into config fields
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
module epcl_loader #(
    parameter int NPORT = epcl_pkg::NUM_PORTS,
    parameter logic DEF_SLOT = 1'b0,
    parameter logic DEF_CLK = 1'b0,
    parameter logic DEF_DSI = 1'b0,
    parameter logic DEF_LPVC = 1'b0,
    parameter logic [2:0] DEF_PNUM = 3'h0,
    parameter logic [6:0] DEF_TCMAP = 7'h00,
    parameter logic [12:0] DEF_PB = 13'h0000
) (
    input wire logic clk_sys,
    input wire logic rst,
    // words from the configuration memory reader
    input wire logic cfg_word_valid,
    input wire logic [7:0] cfg_word_addr,
    input wire logic [15:0] cfg_word_data,
    input wire logic cfg_load_end,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [14:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // loaded port 5 fields towards its register file
    output logic p5_slot_impl,
    output logic p5_slot_clk,
    output logic p5_dsi_req,
    output logic p5_lpvc_vc1,
    output logic [2:0] p5_port_num,
    output logic [6:0] p5_tc_vc0_map,
    output logic cfg_load_done
);

    localparam int PW = epcl_pkg::A_PORT_W; // port index width

    // =========================================================
    // helpers
    // =========================================================

    // true for the six even budget word addresses
    function automatic logic is_pb_addr(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - epcl_pkg::WADDR_PB_BASE;
        is_pb_addr = (a >= epcl_pkg::WADDR_PB_BASE) && !rel[0] &&
            (rel < 8'(NPORT * epcl_pkg::WADDR_PB_STEP));
    endfunction

    // port number of a budget word address
    function automatic logic [PW-1:0] pb_port(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - epcl_pkg::WADDR_PB_BASE;
        pb_port = rel[PW:1];
    endfunction

    // keeps the memory index inside the array
    function automatic logic [PW-1:0] clamp_port(input logic [PW-1:0] p);
        clamp_port = (p < PW'(NPORT)) ? p : '0;
    endfunction

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic slot_impl;            // port 5 slot implemented
        logic slot_clk;             // port 5 connector clock
        logic dsi;                  // port 5 init required
        logic lpvc;                 // port 5 vc1 low priority
        logic [2:0] pnum;           // port 5 logical number
        logic [6:0] tcmap;          // port 5 tc to vc0 map
        logic [NPORT-1:0] pb_vld;   // budget word seen per port
        logic done;                 // load sequence finished
        logic lock;                 // software froze the fields
        logic [7:0] wcnt;           // mapped words accepted
        logic rdy;                  // answer prepared
        logic err;                  // answer is an error
        logic [31:0] rdata;         // prepared read data
    } epcl_state_t;

    epcl_state_t st_q;
    epcl_state_t st_d;

    // budget memory ports
    logic mem_we;
    logic [PW-1:0] mem_waddr;
    logic [12:0] mem_wdata;
    logic [PW-1:0] mem_raddr;
    logic [12:0] mem_rdata;

    // apb address split
    logic [PW-1:0] a_port;
    logic [11:0] a_off;
    logic a_cfg;           // address lies in a port's config space
    logic a_pbport;        // port that owns budget registers
    logic [12:0] pb_word;  // budget entry or its default

    assign a_port = paddr[epcl_pkg::A_PORT_LO +: PW];
    assign a_off = paddr[epcl_pkg::A_OFF_W-1:0];
    assign a_cfg = (a_port != epcl_pkg::PORT_GLOBAL);
    assign a_pbport = (a_port < PW'(NPORT));
    // memory reads during setup so data stand in the access phase
    assign mem_raddr = clamp_port(a_port);

    // =========================================================
    // budget word store, one entry per port
    // =========================================================
    epcl_pbmem #(
        .WIDTH(epcl_pkg::PB_W),
        .DEPTH(NPORT),
        .AW(PW)
    ) u_pbmem (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    // unloaded ports answer with the default entry
    always_comb begin
        if (a_pbport && st_q.pb_vld[mem_raddr]) begin
            pb_word = mem_rdata;
        end else begin
            pb_word = DEF_PB;
        end
    end

    // =========================================================
    // next state: word loading and apb answers
    // =========================================================
    always_comb begin
        st_d = st_q;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;

        // ---- loading; a lock from software freezes all fields
        if (cfg_word_valid && !st_q.lock) begin
            if (cfg_word_addr == epcl_pkg::WADDR_P5) begin
                // bits 7 and 8 of this word have no home
                st_d.slot_impl = cfg_word_data[epcl_pkg::W_SLOT];
                st_d.slot_clk = cfg_word_data[epcl_pkg::W_CLK];
                st_d.dsi = cfg_word_data[epcl_pkg::W_DSI];
                st_d.lpvc = cfg_word_data[epcl_pkg::W_LPVC];
                st_d.pnum =
                    cfg_word_data[epcl_pkg::W_PNUM_LO +: 3];
                st_d.tcmap =
                    cfg_word_data[epcl_pkg::W_TC_LO +: 7];
                st_d.wcnt = st_q.wcnt + 8'h01;
            end else if (is_pb_addr(cfg_word_addr)) begin
                // bit 12 to 14 of a budget word are dropped
                mem_we = 1'b1;
                mem_waddr = pb_port(cfg_word_addr);
                mem_wdata[epcl_pkg::E_BASE_LO +: epcl_pkg::BASE_W] =
                    cfg_word_data[epcl_pkg::W_BASE_LO +:
                    epcl_pkg::BASE_W];
                mem_wdata[epcl_pkg::E_SCALE_LO +: epcl_pkg::SCALE_W] =
                    cfg_word_data[epcl_pkg::W_SCALE_LO +:
                    epcl_pkg::SCALE_W];
                mem_wdata[epcl_pkg::E_PMST_LO +: epcl_pkg::PMST_W] =
                    cfg_word_data[epcl_pkg::W_PMST_LO +:
                    epcl_pkg::PMST_W];
                mem_wdata[epcl_pkg::E_ALLOC] =
                    cfg_word_data[epcl_pkg::W_ALLOC];
                st_d.pb_vld[pb_port(cfg_word_addr)] = 1'b1;
                st_d.wcnt = st_q.wcnt + 8'h01;
            end
            // any other address is not ours: ignored
        end
        if (cfg_load_end) begin
            st_d.done = 1'b1;
        end

        // ---- apb: prepare the answer in the first access cycle
        if (psel && penable && !st_q.rdy &&
            (!a_cfg || st_q.done)) begin
            // config space stalls until the load has finished
            st_d.rdy = 1'b1;
            st_d.err = 1'b0;
            st_d.rdata = '0;
            if (!a_cfg) begin
                // loader control space
                case (a_off)
                    epcl_pkg::OFF_CTRL: begin
                        st_d.rdata[epcl_pkg::CTRL_LOCK] = st_q.lock;
                    end
                    epcl_pkg::OFF_STAT: begin
                        st_d.err = pwrite; // status is read only
                        st_d.rdata[epcl_pkg::STAT_DONE] = st_q.done;
                        st_d.rdata[epcl_pkg::STAT_CNT_LO +:
                            epcl_pkg::CNT_W] = st_q.wcnt;
                    end
                    default: begin
                        st_d.err = 1'b1;
                    end
                endcase
            end else begin
                // loaded fields are read only to software
                st_d.err = pwrite;
                case (a_off)
                    epcl_pkg::OFF_CAP: begin
                        st_d.err = pwrite || (a_port != 3'h5);
                        st_d.rdata[epcl_pkg::R_SLOT] =
                            st_q.slot_impl;
                    end
                    epcl_pkg::OFF_SLOTCLK: begin
                        st_d.err = pwrite || (a_port != 3'h5);
                        st_d.rdata[epcl_pkg::R_CLK] = st_q.slot_clk;
                    end
                    epcl_pkg::OFF_DSI: begin
                        st_d.err = pwrite || (a_port != 3'h5);
                        st_d.rdata[epcl_pkg::R_DSI] = st_q.dsi;
                    end
                    epcl_pkg::OFF_LPVC: begin
                        st_d.err = pwrite || (a_port != 3'h5);
                        st_d.rdata[epcl_pkg::R_LPVC] = st_q.lpvc;
                    end
                    epcl_pkg::OFF_PNUM: begin
                        st_d.err = pwrite || (a_port != 3'h5);
                        st_d.rdata[epcl_pkg::R_PNUM_LO +:
                            epcl_pkg::PNUM_W] = st_q.pnum;
                    end
                    epcl_pkg::OFF_TCMAP: begin
                        st_d.err = pwrite || (a_port != 3'h5);
                        st_d.rdata[epcl_pkg::R_TC_LO +:
                            epcl_pkg::TC_W] = st_q.tcmap;
                    end
                    epcl_pkg::OFF_PBDATA: begin
                        st_d.err = pwrite || !a_pbport;
                        st_d.rdata[epcl_pkg::R_BASE_LO +:
                            epcl_pkg::BASE_W] =
                            pb_word[epcl_pkg::E_BASE_LO +:
                            epcl_pkg::BASE_W];
                        st_d.rdata[epcl_pkg::R_SCALE_LO +:
                            epcl_pkg::SCALE_W] =
                            pb_word[epcl_pkg::E_SCALE_LO +:
                            epcl_pkg::SCALE_W];
                        st_d.rdata[epcl_pkg::R_PMST_LO +:
                            epcl_pkg::PMST_W] =
                            pb_word[epcl_pkg::E_PMST_LO +:
                            epcl_pkg::PMST_W];
                    end
                    epcl_pkg::OFF_PBCAP: begin
                        st_d.err = pwrite || !a_pbport;
                        st_d.rdata[epcl_pkg::R_ALLOC] =
                            pb_word[epcl_pkg::E_ALLOC];
                    end
                    default: begin
                        st_d.err = 1'b1;
                    end
                endcase
            end
            // an error answer carries no data
            if (st_d.err) begin
                st_d.rdata = '0;
            end
        end

        // ---- apb: completion edge; the only place a write acts
        if (psel && penable && st_q.rdy) begin
            st_d.rdy = 1'b0;
            if (pwrite && !a_cfg && (a_off == epcl_pkg::OFF_CTRL)) begin
                st_d.lock = pwdata[epcl_pkg::CTRL_LOCK];
            end
        end
    end

    // =========================================================
    // state register; unloaded fields start at their defaults
    // =========================================================
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q.slot_impl <= DEF_SLOT;
            st_q.slot_clk <= DEF_CLK;
            st_q.dsi <= DEF_DSI;
            st_q.lpvc <= DEF_LPVC;
            st_q.pnum <= DEF_PNUM;
            st_q.tcmap <= DEF_TCMAP;
            st_q.pb_vld <= '0;
            st_q.done <= 1'b0;
            st_q.lock <= 1'b0;
            st_q.wcnt <= '0;
            st_q.rdy <= 1'b0;
            st_q.err <= 1'b0;
            st_q.rdata <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    // ready is a handshake term; data come straight from flops
    assign pready = psel && penable && st_q.rdy;
    assign pslverr = pready && st_q.err;
    assign prdata = st_q.rdata;
    assign p5_slot_impl = st_q.slot_impl;
    assign p5_slot_clk = st_q.slot_clk;
    assign p5_dsi_req = st_q.dsi;
    assign p5_lpvc_vc1 = st_q.lpvc;
    assign p5_port_num = st_q.pnum;
    assign p5_tc_vc0_map = st_q.tcmap;
    assign cfg_load_done = st_q.done;

endmodule

/* File: testbench/epcl_chk.sv */
// concurrent checks on the port configuration loader ports
`timescale 1ns/1ns
module epcl_chk (
    input logic clk_sys,
    input logic rst,
    input logic cfg_word_valid,
    input logic [7:0] cfg_word_addr,
    input logic [15:0] cfg_word_data,
    input logic cfg_load_end,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [14:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic p5_slot_impl,
    input logic p5_slot_clk,
    input logic p5_dsi_req,
    input logic p5_lpvc_vc1,
    input logic [2:0] p5_port_num,
    input logic [6:0] p5_tc_vc0_map,
    input logic cfg_load_done
);
    // ====================
    // helper: lock bit as software last wrote it
    // ====================
    logic lock_q; // words are dropped while set
    logic take; // slot word accepted this edge
    assign take = cfg_word_valid && cfg_word_addr == 8'h6a && !lock_q;
    // track completed writes to the control word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_q <= 1'b0;
        end else if (pready && pwrite && paddr == 15'h7000) begin
            lock_q <= pwdata[0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ====================
    // steps: a slot word taken, a slot read completed
    // ====================
    sequence s_take;
        take;
    endsequence
    sequence s_rd;
        pready && !pwrite && paddr == 15'h50c0;
    endsequence
    slot_copy_a: assert property (s_take |=>
        p5_slot_impl == $past(cfg_word_data[0])) else $error("slot bit");
    clk_copy_a: assert property (s_take |=>
        p5_slot_clk == $past(cfg_word_data[1])) else $error("clock bit");
    dsi_copy_a: assert property (s_take |=>
        p5_dsi_req == $past(cfg_word_data[2])) else $error("init bit");
    lpvc_copy_a: assert property (s_take |=>
        p5_lpvc_vc1 == $past(cfg_word_data[3])) else $error("vc bit");
    pnum_copy_a: assert property (s_take |=>
        p5_port_num == $past(cfg_word_data[6:4])) else $error("port num");
    tcmap_copy_a: assert property (s_take |=>
        p5_tc_vc0_map == $past(cfg_word_data[15:9])) else $error("tc map");
    field_hold_a: assert property (!take |=> $stable({p5_tc_vc0_map,
        p5_port_num, p5_lpvc_vc1, p5_dsi_req, p5_slot_clk, p5_slot_impl}))
        else $error("field moved");
    done_sticky_a: assert property (cfg_load_end || cfg_load_done
        |=> cfg_load_done) else $error("done lost");
    stall_load_a: assert property (pready && paddr[14:12] != 3'h7
        |-> cfg_load_done) else $error("access before load");
    slot_read_a: assert property (s_rd |-> !pslverr
        && prdata == {7'h00, p5_slot_impl, 24'h0}) else $error("slot read");
endmodule

bind epcl_loader epcl_chk epcl_chk_inst (.clk_sys, .rst, .cfg_word_valid,
    .cfg_word_addr, .cfg_word_data, .cfg_load_end, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .p5_slot_impl, .p5_slot_clk,
    .p5_dsi_req, .p5_lpvc_vc1, .p5_port_num, .p5_tc_vc0_map, .cfg_load_done);

/* File: testbench/epcl_mem_model.sv */
// behavioural memory reader: walks a word image once per start pulse
`timescale 1ns/1ns
module epcl_mem_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] gap,
    output logic cfg_word_valid,
    output logic [7:0] cfg_word_addr,
    output logic [15:0] cfg_word_data,
    output logic cfg_load_end,
    output logic busy
);
    logic [15:0] mem [0:7]; // slot word, stray word, six budget words
    // word address of image entry k
    function automatic logic [7:0] addr_of(input int k);
        if (k == 0) return 8'h6a;
        if (k == 1) return 8'h6c; // not a loader word, must be ignored
        return 8'h70 + 8'(2 * (k - 2));
    endfunction
    // ====================
    // one pass over the image, gap idle cycles between words
    // ====================
    initial begin
        cfg_word_valid = 1'b0;
        cfg_word_addr = 8'h00;
        cfg_word_data = 16'h0000;
        cfg_load_end = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (start && !rst) begin
                busy <= 1'b1;
                for (int i = 0; i < 8; i++) begin
                    cfg_word_valid <= 1'b1;
                    cfg_word_addr <= addr_of(i);
                    cfg_word_data <= mem[i];
                    @(posedge clk_sys);
                    if (gap != 4'h0) begin
                        // idle lines show the inverse, never the last word
                        cfg_word_valid <= 1'b0;
                        cfg_word_addr <= ~addr_of(i);
                        cfg_word_data <= ~mem[i];
                        repeat (gap) @(posedge clk_sys);
                    end
                end
                cfg_word_valid <= 1'b0;
                cfg_word_addr <= ~addr_of(7);
                cfg_word_data <= ~mem[7];
                cfg_load_end <= 1'b1;
                @(posedge clk_sys);
                cfg_load_end <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the port configuration loader
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [14:0] paddr = 15'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cfg_load_done, busy;
    logic cfg_word_valid, cfg_load_end;
    logic [7:0] cfg_word_addr;
    logic [15:0] cfg_word_data;
    logic start = 1'b0; // one pass of the memory model
    logic [3:0] gap = 4'h0; // idle cycles between words
    logic p5_slot_impl, p5_slot_clk, p5_dsi_req, p5_lpvc_vc1;
    logic [2:0] p5_port_num;
    logic [6:0] p5_tc_vc0_map;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 6085;
    logic [15:0] ex [0:7]; // image the loader should hold
    logic [32:0] expq [$]; // {pslverr, prdata} per transfer
    always #50 clk_sys = ~clk_sys;
    epcl_loader epcl_loader_inst (.clk_sys, .rst, .cfg_word_valid,
        .cfg_word_addr, .cfg_word_data, .cfg_load_end, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .p5_slot_impl,
        .p5_slot_clk, .p5_dsi_req, .p5_lpvc_vc1, .p5_port_num,
        .p5_tc_vc0_map, .cfg_load_done);
    epcl_mem_model epcl_mem_model_inst (.clk_sys, .rst, .start, .gap,
        .cfg_word_valid, .cfg_word_addr, .cfg_word_data, .cfg_load_end,
        .busy);
    // ====================
    // verdict and compare helpers
    // ====================
    task automatic summarize();
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // monitor: takes the answer at the edge that completes it
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            cmp({pslverr, prdata}, expq.pop_front());
        end
    end
    // ====================
    // apb master: one edge of idle first, so no double drive
    // ====================
    task automatic apb(input logic w, input logic [14:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge clk_sys);
        expq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // new random image; keep leaves the expectation as it was
    task automatic load(input bit keep, input logic [3:0] g);
        logic [15:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            epcl_mem_model_inst.mem[i] = v;
            if (!keep) ex[i] = v;
        end
        gap <= g;
        @(posedge clk_sys);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
    endtask
    task automatic idle();
        do @(negedge clk_sys); while (busy !== 1'b0);
    endtask
    // every loaded field over apb, the port 5 fields at the outputs too
    task automatic check_all();
        logic [15:0] w;
        w = ex[0];
        cmp({19'h0, p5_tc_vc0_map, p5_port_num, p5_lpvc_vc1, p5_dsi_req,
            p5_slot_clk, p5_slot_impl}, {19'h0, w[15:9], w[6:0]});
        apb(1'b0, 15'h50c0, 32'h0, {1'b0, 7'h0, w[0], 24'h0});
        apb(1'b0, 15'h50d0, 32'h0, {1'b0, 3'h0, w[1], 28'h0});
        apb(1'b0, 15'h5040, 32'h0, {1'b0, 10'h0, w[2], 21'h0});
        apb(1'b0, 15'h5144, 32'h0, {1'b0, 27'h0, w[3], 4'h0});
        apb(1'b0, 15'h50cc, 32'h0, {1'b0, 5'h0, w[6:4], 24'h0});
        apb(1'b0, 15'h5154, 32'h0, {1'b0, 24'h0, w[15:9], 1'b0});
        for (int p = 0; p < 6; p++) begin
            w = ex[p + 2];
            apb(1'b0, {3'(p), 12'h214}, 32'h0,
                {1'b0, 17'h0, w[11:10], 3'h0, w[9:0]});
            apb(1'b0, {3'(p), 12'h218}, 32'h0, {32'h0, w[15]});
        end
    endtask
    // ====================
    // main sequence
    // ====================
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        load(1'b0, 4'h0);
        // issued while loading: must stall until done
        apb(1'b0, 15'h50c0, 32'h0, {1'b0, 7'h0, ex[0][0], 24'h0});
        idle();
        check_all();
        apb(1'b0, 15'h00c0, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 15'h5100, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 15'h6214, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 15'h50c0, 32'($random(seed)), {1'b1, 32'h0});
        apb(1'b0, 15'h7004, 32'h0, {1'b0, 32'h0701});
        apb(1'b1, 15'h7004, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 15'h7008, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 15'h7000, 32'h1, 33'h0);
        apb(1'b0, 15'h7000, 32'h0, 33'h1);
        load(1'b1, 4'h2); // locked: every word must be dropped
        idle();
        check_all();
        apb(1'b1, 15'h7000, 32'h0, 33'h1);
        load(1'b0, 4'h3); // unlocked reload, slow words
        idle();
        check_all();
        apb(1'b0, 15'h7004, 32'h0, {1'b0, 32'h0e01});
        // second reset clears fields and done
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        cmp({18'h0, p5_tc_vc0_map, p5_port_num, p5_lpvc_vc1, p5_dsi_req,
            p5_slot_clk, p5_slot_impl, cfg_load_done}, 33'h0);
        summarize();
    end
    // watchdog well beyond the few hundred cycles expected
    initial begin
        #(100 * 20000);
        fail_count++;
        summarize();
    end
endmodule
